//--- test/ptp_link_asserts.sv
// Assertions on the link between controller and device
`timescale 1ns/1ns
module ptp_link_asserts (
    input wire logic tx_clk,
    input wire logic reset_n,
    input wire logic transmit_idle_force,
    input wire logic [1:0] power_state_select,
    input wire logic phy_op_done_strobe
);
    logic [10:0] since_r;
    logic deep_wait_r;
    logic [10:0] deep_cnt_r;
    default clocking @(posedge tx_clk);
    endclocking
    default disable iff (!reset_n);
    // Link cycles since the last power request
    always_ff @(posedge tx_clk)
    begin
        if (!reset_n || $changed(power_state_select))
            since_r <= 11'h000;
        else if (since_r != 11'h7ff)
            since_r <= since_r + 11'h001;
    end
    // Link cycles spent waiting on a deep save exit
    always_ff @(posedge tx_clk)
    begin
        if (!reset_n || phy_op_done_strobe)
        begin
            deep_wait_r <= 1'b0;
            deep_cnt_r <= 11'h000;
        end
        else if ($past(power_state_select) == 2'h2 &&
            power_state_select == 2'h0)
        begin
            deep_wait_r <= 1'b1;
            deep_cnt_r <= 11'h000;
        end
        else if (deep_wait_r && deep_cnt_r != 11'h7ff)
            deep_cnt_r <= deep_cnt_r + 11'h001;
    end
    a_reset_quiet: assert property (
        disable iff (1'b0) !reset_n |-> !phy_op_done_strobe)
        else $error("done strobe during reset");
    a_code_legal: assert property (
        power_state_select != 2'h3) else $error("unused power code");
    a_idle_saving: assert property (
        power_state_select != 2'h0 |-> transmit_idle_force)
        else $error("idle released in saving state");
    a_deep_exit: assert property (
        deep_wait_r |-> deep_cnt_r < 11'h3ec) else $error("deep exit late");
    a_quick_enter: assert property (
        $past(power_state_select) == 2'h0 && power_state_select == 2'h1
        |-> ##[1:12] phy_op_done_strobe) else $error("quick entry late");
    a_quick_exit: assert property (
        $past(power_state_select) == 2'h1 && power_state_select == 2'h0
        |-> ##[1:8] phy_op_done_strobe) else $error("quick exit late");
    a_done_pulse: assert property (
        phy_op_done_strobe |=> !phy_op_done_strobe)
        else $error("done strobe too long");
    a_done_caused: assert property (
        phy_op_done_strobe |-> since_r <= 11'h3f0)
        else $error("done strobe without request");
endmodule

//--- test/testbench.sv
// Self-checking bench for the controller and device pair
`timescale 1ns/1ns
module testbench;
    import ptp_pkg::*;
    logic clk, rst, wr, rd, sv, sk;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] act;
    logic [7:0] sb;
    logic [8:0] q[$];
    int error_cnt = 0, samples_checked = 0, cyc = 0, n;
    logic [17:0] words[4] = '{18'h1_a53c, 18'h2_1234, 18'h3_bc0f, 18'h0_7e81};
    ptp_link_if link ();
    ptp_controller ptp_controller_inst (.I_CORE_CLK(clk), .I_RESET(rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .link(link));
    ptp_device ptp_device_inst (.link(link), .o_active_power(act),
        .o_sym_valid(sv), .o_sym_byte(sb), .o_sym_ctrl(sk));
    ptp_link_asserts ptp_link_asserts_inst (.tx_clk(link.tx_clk),
        .reset_n(link.reset_n),
        .transmit_idle_force(link.transmit_idle_force),
        .power_state_select(link.power_state_select),
        .phy_op_done_strobe(link.phy_op_done_strobe));
    // Core clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Symbols seen at the device, mid-period
    always @(negedge link.tx_clk)
        if (sv === 1'b1)
            q.push_back({sk, sb});
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            error_cnt++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic wait_pwr(input logic [1:0] p, input int lim);
        n = 0;
        while (act !== p && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(act, p);
        repeat (64) @(posedge clk);
    endtask
    // Word held on the link, then a clean window of symbols
    task automatic hold(input logic [17:0] w);
        wreg(PTP_REG_DATA, {14'h0000, w});
        repeat (8) @(posedge link.tx_clk);
        q.delete();
        repeat (8) @(posedge link.tx_clk);
    endtask
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(PTP_REG_CTRL, {27'h0, PTP_CTRL_RESET});
        rchk(4'h5, 32'h0000_0000);
        wreg(4'h7, 32'hffff_ffff);
        rchk(PTP_REG_CTRL, {27'h0, PTP_CTRL_RESET});
        rchk(PTP_REG_STATUS, 32'h0000_0000);
        wreg(PTP_REG_CTRL, 32'h0000_0006);
        hold(18'h0_1234);
        chk(q.size(), 0);
        wreg(PTP_REG_CTRL, 32'h0000_0004);
        wait (link.power_state_select === 2'h0);
        wait_pwr(2'h0, 20000);
        chk(n <= PTP_DEEP_EXIT_NS / 4 + 16, 1);
        rchk(PTP_REG_STATUS, 32'h0000_0001);
        hold(18'h0_1234);
        chk(q.size(), 0);
        wreg(PTP_REG_CTRL, 32'h0000_0000);
        foreach (words[i])
        begin
            hold(words[i]);
            v = 0;
            for (int j = 0; j + 1 < q.size(); j++)
                if (q[j] === {words[i][16], words[i][7:0]} &&
                    q[j + 1] === {words[i][17], words[i][15:8]})
                    v = 1;
            chk(v, 1);
        end
        wreg(PTP_REG_CTRL, 32'h0000_0005);
        wait_pwr(2'h1, 200);
        rchk(PTP_REG_STATUS, 32'h0000_0002);
        wreg(PTP_REG_CTRL, 32'h0000_0004);
        wait_pwr(2'h0, 200);
        rchk(PTP_REG_STATUS, 32'h0000_0003);
        // Device reset with dual-edge select, then select dropped
        wreg(PTP_REG_CTRL, 32'h0000_001e);
        wait (link.reset_n === 1'b0);
        #1;
        chk(act, 2'h2);
        repeat (32) @(posedge clk);
        wreg(PTP_REG_CTRL, 32'h0000_000e);
        repeat (32) @(posedge clk);
        wreg(PTP_REG_CTRL, 32'h0000_000c);
        wait_pwr(2'h0, 20000);
        wreg(PTP_REG_CTRL, 32'h0000_0000);
        foreach (words[i])
        begin
            hold(words[i]);
            v = q.size() > 0;
            foreach (q[j])
                if (q[j] !== {words[i][16], words[i][7:0]})
                    v = 0;
            chk(v, 1);
        end
        test_done;
    end
endmodule

//--- verilog/ptp_controller.sv
// Controller end: register port, link clock divider, word driver
`timescale 1ns/1ns
module ptp_controller (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    ptp_link_if.controller link
);
    import ptp_pkg::*;

    logic [4:0] ctrl_r;
    logic [17:0] data_r;
    logic [3:0] div_r;
    logic clk_r;
    logic done_s;
    logic done_d_r;
    logic [7:0] done_cnt_r;
    logic [17:0] link_r;

    // Register writes
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            ctrl_r <= PTP_CTRL_RESET;
            data_r <= 18'h0_0000;
        end
        else if (I_WR && I_ADDR == PTP_REG_CTRL)
            ctrl_r <= I_WDATA[4:0];
        else if (I_WR && I_ADDR == PTP_REG_DATA)
            data_r <= I_WDATA[17:0];
    end

    // Link clock divider
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            div_r <= 4'h0;
            clk_r <= 1'b0;
        end
        else if (div_r == 4'(PTP_CLK_HALF_DIV - 1))
        begin
            div_r <= 4'h0;
            clk_r <= ~clk_r;
        end
        else
            div_r <= div_r + 4'h1;
    end

    // Launch link signals on the falling link clock edge
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
            link_r <= 18'h0_0000;
        else if (clk_r && div_r == 4'(PTP_CLK_HALF_DIV - 1))
            // upper lines grounded in dual edge mode
            link_r <= ctrl_r[PTP_CTRL_DDR_BIT] ?
                {1'b0, data_r[16], 8'h00, data_r[7:0]} : data_r;
    end

    ptp_sync2 #(.W(1)) u_done_sync (
        .i_clk(I_CORE_CLK),
        .i_d(link.phy_op_done_strobe),
        .o_q(done_s)
    );

    // count completions seen from the device
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            done_d_r <= 1'b0;
            done_cnt_r <= 8'h00;
        end
        else
        begin
            done_d_r <= done_s;
            if (done_s && !done_d_r)
                done_cnt_r <= done_cnt_r + 8'h01;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
            O_RDATA <= 32'h0000_0000;
        else if (I_RD && I_ADDR == PTP_REG_CTRL)
            O_RDATA <= {27'h000_0000, ctrl_r};
        else if (I_RD && I_ADDR == PTP_REG_DATA)
            O_RDATA <= {14'h0000, data_r};
        else if (I_RD && I_ADDR == PTP_REG_STATUS)
            O_RDATA <= {24'h00_0000, done_cnt_r};
        else
            O_RDATA <= 32'h0000_0000;
    end

    assign link.tx_clk = clk_r;
    // software holds the device in reset
    assign link.reset_n = ~ctrl_r[PTP_CTRL_RST_BIT];
    assign link.ddr_select = ctrl_r[PTP_CTRL_DDR_BIT];
    // power select and idle force from software
    assign link.power_state_select = ctrl_r[1:0];
    assign link.transmit_idle_force = ctrl_r[PTP_CTRL_IDLE_BIT];
    assign link.tx_data = link_r[15:0];
    assign link.transmit_control_flags = link_r[17:16];
endmodule

//--- verilog/ptp_device.sv
// Physical layer device end: parallel capture, serialising, power states
// Notes on behaviour
// - Reset is active low and asynchronous.
// - Power select 00 full, 01 quick, 10 deep.
// - Deep save exit completes within 64 us.
// - Done strobe reports completed power transitions.
// - Select low at release: 16-bit rising capture.
// - Select high at release: 8-bit both edges.
// - Single edge: low byte first, high second.
// - Dual edge: rising byte first, falling second.
// - Controller grounds unused upper lines in dual.
// - Flag 0 marks low byte, 1 high.
// - Dual edge: flag 0 marks same-phase byte.
// - Flag one marks control symbol, zero data.
// - Idle force low only for valid data.
`timescale 1ns/1ns
module ptp_device (
    ptp_link_if.device link,
    output logic [1:0] o_active_power,
    output logic o_sym_valid,
    output logic [7:0] o_sym_byte,
    output logic o_sym_ctrl
);
    import ptp_pkg::*;

    logic ddr_mode_r;
    logic seen_rst_r;
    logic [7:0] fall_byte_r;
    logic fall_ctrl_r;
    logic [15:0] word_r;
    logic [1:0] flags_r;
    logic word_ok_r;
    logic half_r;
    logic [1:0] active_r;
    logic [1:0] target_r;
    logic [12:0] wait_r;
    logic done_r;
    logic ser_r;

    // asynchronous reset; capture select once after release
    always_ff @(posedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            seen_rst_r <= 1'b0;
            ddr_mode_r <= 1'b0;
        end
        else if (!seen_rst_r)
        begin
            seen_rst_r <= 1'b1;
            ddr_mode_r <= link.ddr_select;
        end
    end

    // falling edge half of the dual edge transfer
    always_ff @(negedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            fall_byte_r <= 8'h00;
            fall_ctrl_r <= 1'b0;
        end
        else
        begin
            // low flag follows its own phase
            fall_byte_r <= link.tx_data[7:0];
            fall_ctrl_r <= link.transmit_control_flags[0];
        end
    end

    // rising capture; dual mode pairs with previous falling byte
    always_ff @(posedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            word_r <= 16'h0000;
            flags_r <= 2'h0;
            word_ok_r <= 1'b0;
        end
        else if (ddr_mode_r)
        begin
            // falling byte earlier, rising byte after it
            word_r <= {fall_byte_r, word_r[7:0]};
            flags_r <= {fall_ctrl_r, flags_r[0]};
            if (!half_r)
            begin
                word_r[7:0] <= link.tx_data[7:0];
                flags_r[0] <= link.transmit_control_flags[0];
            end
            // data valid only at full power with idle low
            word_ok_r <= !link.transmit_idle_force &&
                active_r == PTP_PWR_FULL_ON;
        end
        else
        begin
            word_r <= link.tx_data;
            flags_r <= link.transmit_control_flags;
            word_ok_r <= !link.transmit_idle_force &&
                active_r == PTP_PWR_FULL_ON;
        end
    end

    always_ff @(posedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            half_r <= 1'b0;
            o_sym_valid <= 1'b0;
            o_sym_byte <= 8'h00;
            o_sym_ctrl <= 1'b0;
        end
        else
        begin
            // Alternate first and second symbol in both modes
            half_r <= ~half_r;
            o_sym_valid <= word_ok_r;
            // low byte first, high byte second
            o_sym_byte <= half_r ? word_r[15:8] : word_r[7:0];
            o_sym_ctrl <= half_r ? flags_r[1] : flags_r[0];
        end
    end

    // line idles when forced, else differential parity of the held word
    always_ff @(posedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
            ser_r <= 1'b0;
        else
            ser_r <= link.transmit_idle_force ? 1'b0 : ^word_r;
    end
    assign link.serial_out_pos = ser_r;
    assign link.serial_out_neg = ~ser_r & ~link.transmit_idle_force;

    always_ff @(posedge link.tx_clk or negedge link.reset_n)
    begin
        if (!link.reset_n)
        begin
            active_r <= PTP_PWR_DEEP_SAVE;
            target_r <= PTP_PWR_DEEP_SAVE;
            wait_r <= 13'h0000;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (wait_r != 13'h0000)
            begin
                wait_r <= wait_r - 13'h0001;
                if (wait_r == 13'h0001)
                begin
                    active_r <= target_r;
                    done_r <= 1'b1;
                end
            end
            else if (link.power_state_select != active_r &&
                link.power_state_select != 2'h3)
            begin
                target_r <= link.power_state_select;
                // deep exit bounded by the recovery count
                if (active_r == PTP_PWR_DEEP_SAVE)
                    wait_r <= 13'(PTP_DEEP_EXIT_CYC);
                else if (active_r == PTP_PWR_QUICK_SAVE)
                    wait_r <= 13'(PTP_QUICK_EXIT_CYC);
                else
                    wait_r <= 13'(PTP_CHANGE_CYC);
            end
        end
    end
    assign link.phy_op_done_strobe = done_r;
    assign o_active_power = active_r;
endmodule

//--- verilog/ptp_link_if.sv
// Interface joining the controller and the physical layer device
`timescale 1ns/1ns
interface ptp_link_if;
    logic tx_clk;
    logic reset_n;
    logic ddr_select;
    logic [15:0] tx_data;
    logic [1:0] transmit_control_flags;
    logic transmit_idle_force;
    logic [1:0] power_state_select;
    logic phy_op_done_strobe;
    logic serial_out_pos;
    logic serial_out_neg;
    modport device (
        input tx_clk, reset_n, ddr_select, tx_data,
        input transmit_control_flags, transmit_idle_force,
        input power_state_select,
        output phy_op_done_strobe, serial_out_pos, serial_out_neg
    );
    modport controller (
        output tx_clk, reset_n, ddr_select, tx_data,
        output transmit_control_flags, transmit_idle_force,
        output power_state_select,
        input phy_op_done_strobe
    );
endinterface

//--- verilog/ptp_pkg.sv
// Shared constants and types for the transmit parallel port link
package ptp_pkg;
    // Power state encodings
    typedef enum logic [1:0] {
        PTP_PWR_FULL_ON = 2'h0,
        PTP_PWR_QUICK_SAVE = 2'h1,
        PTP_PWR_DEEP_SAVE = 2'h2
    } ptp_power_t;
    // Link data widths
    localparam int PTP_DATA_W = 16;
    localparam int PTP_BYTE_W = 8;
    // Recovery times in nanoseconds
    localparam int PTP_DEEP_EXIT_NS = 64000;
    localparam int PTP_QUICK_EXIT_NS = 100;
    localparam int PTP_CHANGE_NS = 256;
    // Link clock period in nanoseconds
    localparam int PTP_LINK_PERIOD_NS = 64;
    // All times round down, none below one cycle
    localparam int PTP_DEEP_EXIT_CYC =
        (PTP_DEEP_EXIT_NS / PTP_LINK_PERIOD_NS) < 1 ? 1 :
        (PTP_DEEP_EXIT_NS / PTP_LINK_PERIOD_NS);
    localparam int PTP_QUICK_EXIT_CYC =
        (PTP_QUICK_EXIT_NS / PTP_LINK_PERIOD_NS) < 1 ? 1 :
        (PTP_QUICK_EXIT_NS / PTP_LINK_PERIOD_NS);
    localparam int PTP_CHANGE_CYC =
        (PTP_CHANGE_NS / PTP_LINK_PERIOD_NS) < 1 ? 1 :
        (PTP_CHANGE_NS / PTP_LINK_PERIOD_NS);
    // Controller link clock divider: half period in core cycles
    localparam int PTP_CLK_HALF_DIV = 8;
    // Controller register offsets
    localparam logic [3:0] PTP_REG_CTRL = 4'h0;
    localparam logic [3:0] PTP_REG_DATA = 4'h1;
    localparam logic [3:0] PTP_REG_STATUS = 4'h2;
    // Control register field positions
    localparam int PTP_CTRL_PWR_LSB = 0;
    localparam int PTP_CTRL_IDLE_BIT = 2;
    localparam int PTP_CTRL_DDR_BIT = 3;
    localparam int PTP_CTRL_RST_BIT = 4;
    // Control register reset value: held in reset, idle forced, deep save
    localparam logic [4:0] PTP_CTRL_RESET = 5'h16;
endpackage

//--- verilog/ptp_sync2.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/1ns
module ptp_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    // First stage feeds only the second
    always_ff @(posedge i_clk)
    begin
        meta_r <= i_d;
        o_q <= meta_r;
    end
endmodule
